/* File: shared/iarc_regs.vh */
// Purpose: Register map and timing constants of the insulation alarm relay control block.
// Assumes: 32-bit AHB-Lite data, one aligned word per register, 25 MHz hclk.
// Notes: Offsets are byte addresses.
`ifndef IARC_REGS_VH
`define IARC_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IARC_CTRL_OFS 8'h00
`define IARC_STATUS_OFS 8'h04
`define IARC_DELAY_OFS 8'h08
`define IARC_IRQ_STAT_OFS 8'h0C
`define IARC_IRQ_EN_OFS 8'h10
`define IARC_IRQ_CLR_OFS 8'h14

// ----------------------------------------
// Control fields and reset value
// ----------------------------------------
`define IARC_CTRL_ACK_EN 0
`define IARC_CTRL_CORR_EN 1
`define IARC_CTRL_TEST_RLY 2
`define IARC_CTRL_INH_EXT 3
`define IARC_CTRL_INH_FB 4
`define IARC_CTRL_RST 32'h0000_0005
`define IARC_CTRL_MASK 32'h0000_001F

// ----------------------------------------
// Screen codes
// ----------------------------------------
`define IARC_SCR_MEAS 3'h0
`define IARC_SCR_PREV 3'h1
`define IARC_SCR_ALARM 3'h2
`define IARC_SCR_INHIB 3'h3
`define IARC_SCR_MENU 3'h4
`define IARC_SCR_SETTINGS 3'h5
`define IARC_SCR_TEST 3'h6

// ----------------------------------------
// Timing
// ----------------------------------------
`define IARC_CLK_HZ 25000000
`define IARC_PULSE_S 3
`define IARC_MS_DIV (`IARC_CLK_HZ / 1000)
`define IARC_PULSE_MS (`IARC_PULSE_S * 1000)

`endif

/* File: core/iarc_tick.v */
// Purpose: Divider that gives a one-cycle pulse every millisecond.
// Assumes: DIV is at least 2.
// Notes: None.
module iarc_tick #(
	parameter DIV = 25000
) (
	input wire hclk,
	input wire hresetn,
	output reg tick_reg
);

	reg [15:0] cnt_reg;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (cnt_reg == DIV[15:0] - 16'h0001) begin
			cnt_reg <= 16'h0000;
			tick_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
			tick_reg <= 1'b0;
		end
	end

endmodule // iarc_tick

/* File: core/iarc_sync.v */
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Levels that are slow compared with hclk.
// Notes: Stage one feeds only stage two.
module iarc_sync #(
	parameter W = 7
) (
	input wire hclk,
	input wire hresetn,
	input wire [W-1:0] d,
	output reg [W-1:0] q_reg
);

	reg [W-1:0] meta_reg;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_reg <= {W{1'b0}};
			q_reg <= {W{1'b0}};
		end else begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end

endmodule // iarc_sync

/* File: core/iarc_top.v */
// Purpose: Alarm relay, LED and status screen control of an insulation monitor, with an AHB-Lite register file.
// Assumes: Threshold comparison and buttons arrive as pin levels; one 25 MHz clock.
// Notes: Alarm delay is set in milliseconds through the delay register.
`include "iarc_regs.vh"

// What this block does
// - Inhibit active shows the inhibition screen over any measurement or alarm screen.
// - On inhibition screen: menu opens menu, arrows open settings, test starts self-test.
// - Internal inhibit: re-enabling injection runs a self-test before the measurement screen.
// - External inhibit: re-enabling injection returns straight to the measurement screen.
// - Inhibit disconnects the relay under internal kind, keeps it connected under external.
// - Inhibit feedback option, default off, energises alarm relay while inhibited.
// - Below preventive threshold, switch preventive relay and light preventive indicator.
// - Alarm state only after full alarm delay; then alarm relay and LED on.
// - Acknowledge enabled by default: acknowledge in alarm releases both relays.
// - Acknowledge disabled: relays stay active until insulation recovers.
// - Fault cleared turns off the alarm LED and returns to normal.
// - Fault-cleared pulse option re-energises the alarm relay for 3 seconds.
// - Fault-cleared pulse defaults off and only works with acknowledge enabled.
// - Pulse option off: no 3 s pulse, just return to normal.
// - Test relay option, default on: manual self-test toggles both relays 3 seconds.
module iarc_top #(
	parameter PULSE_MS = `IARC_PULSE_MS,
	parameter MS_DIV = `IARC_MS_DIV
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire prev_below,
	input wire alarm_below,
	input wire inhibit_in,
	input wire ack_btn,
	input wire test_btn,
	input wire menu_btn,
	input wire arrow_btn,
	output reg prev_relay,
	output reg alarm_relay,
	output reg prev_led,
	output reg alarm_led,
	output reg relay_connect,
	output reg [2:0] screen,
	output reg test_active,
	output wire irq
);

	// ----------------------------------------
	// Input synchronisation and edges
	// ----------------------------------------
	wire [6:0] sync_q;
	reg [6:0] sync_d_reg;
	wire prev_s = sync_q[0];
	wire alarm_s = sync_q[1];
	wire inh_s = sync_q[2];
	wire [6:0] rise = sync_q & ~sync_d_reg;
	wire ack_p = rise[3];
	wire test_p = rise[4];
	wire menu_p = rise[5];
	wire arrow_p = rise[6];
	wire inh_fall = sync_d_reg[2] & ~inh_s;

	iarc_sync #(.W(7)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d({arrow_btn, menu_btn, test_btn, ack_btn, inhibit_in, alarm_below, prev_below}),
		.q_reg(sync_q)
	);

	wire ms_tick;
	iarc_tick #(.DIV(MS_DIV)) u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick_reg(ms_tick)
	);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_d_reg <= 7'h00;
		end else begin
			sync_d_reg <= sync_q;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [4:0] ctrl_reg;
	reg [23:0] delay_reg;
	reg [3:0] irq_stat_reg;
	reg [3:0] irq_en_reg;
	reg wr_pend_reg;
	reg [7:0] addr_reg;
	reg [31:0] rdata_reg;
	wire ack_en = ctrl_reg[`IARC_CTRL_ACK_EN];
	wire corr_en = ctrl_reg[`IARC_CTRL_CORR_EN];
	wire test_rly = ctrl_reg[`IARC_CTRL_TEST_RLY];
	wire inh_ext = ctrl_reg[`IARC_CTRL_INH_EXT];
	wire inh_fb = ctrl_reg[`IARC_CTRL_INH_FB];
	localparam [31:0] CTRL_RST = `IARC_CTRL_RST;

	// ----------------------------------------
	// Alarm state machine
	// ----------------------------------------
	localparam ST_NORMAL = 2'd0;
	localparam ST_DELAY = 2'd1;
	localparam ST_ALARM = 2'd2;
	localparam ST_ACKED = 2'd3;

	reg [1:0] st_reg;
	reg [23:0] dly_cnt_reg;
	reg [15:0] pulse_cnt_reg;
	reg [15:0] test_cnt_reg;
	reg pulse_on_reg;
	reg test_on_reg;
	reg test_rly_on_reg;
	reg in_menu_reg;
	reg in_set_reg;

	// Marks the last millisecond tick of a pulse or self-test run.
	function timer_last(input [15:0] cnt, input tick);
		begin
			timer_last = (cnt == PULSE_MS[15:0] - 16'h0001) & tick;
		end
	endfunction

	// Tells whether the fault has reached the alarm state, acknowledged or not.
	function fault_held(input [1:0] st);
		begin
			fault_held = (st == ST_ALARM) | (st == ST_ACKED);
		end
	endfunction

	wire delay_done = (dly_cnt_reg >= delay_reg);
	wire pulse_done = timer_last(pulse_cnt_reg, ms_tick);
	wire test_done = timer_last(test_cnt_reg, ms_tick);
	wire enter_alarm = (st_reg == ST_DELAY) & alarm_s & delay_done;
	wire fault_clear = fault_held(st_reg) & ~alarm_s;
	wire start_test_btn = test_p & ~test_on_reg;
	wire start_test_auto = inh_fall & ~inh_ext;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= ST_NORMAL;
			dly_cnt_reg <= 24'h00_0000;
		end else begin
			case (st_reg)
				ST_NORMAL: begin
					dly_cnt_reg <= 24'h00_0000;
					if (alarm_s) begin
						st_reg <= ST_DELAY;
					end
				end
				ST_DELAY: begin
					if (!alarm_s) begin
						st_reg <= ST_NORMAL;
					end else if (delay_done) begin
						st_reg <= ST_ALARM;
					end else if (ms_tick) begin
						dly_cnt_reg <= dly_cnt_reg + 24'h00_0001;
					end
				end
				ST_ALARM: begin
					if (!alarm_s) begin
						st_reg <= ST_NORMAL;
					end else if (ack_p && ack_en) begin
						st_reg <= ST_ACKED;
					end
				end
				ST_ACKED: begin
					if (!alarm_s) begin
						st_reg <= ST_NORMAL;
					end
				end
				default: begin
					st_reg <= ST_NORMAL;
				end
			endcase
		end
	end

	// Fault-cleared pulse and self-test timers.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulse_on_reg <= 1'b0;
			pulse_cnt_reg <= 16'h0000;
		end else if (fault_clear && corr_en && ack_en) begin
			pulse_on_reg <= 1'b1;
			pulse_cnt_reg <= 16'h0000;
		end else if (pulse_on_reg && alarm_s) begin
			pulse_on_reg <= 1'b0;
		end else if (pulse_done) begin
			pulse_on_reg <= 1'b0;
		end else if (pulse_on_reg && ms_tick) begin
			pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			test_on_reg <= 1'b0;
			test_rly_on_reg <= 1'b0;
			test_cnt_reg <= 16'h0000;
		end else if (start_test_btn || start_test_auto) begin
			test_on_reg <= 1'b1;
			test_rly_on_reg <= start_test_btn & test_rly;
			test_cnt_reg <= 16'h0000;
		end else if (test_done) begin
			test_on_reg <= 1'b0;
			test_rly_on_reg <= 1'b0;
		end else if (test_on_reg && ms_tick) begin
			test_cnt_reg <= test_cnt_reg + 16'h0001;
		end
	end

	// Menu navigation from the inhibition screen.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_menu_reg <= 1'b0;
			in_set_reg <= 1'b0;
		end else if (!inh_s) begin
			in_menu_reg <= 1'b0;
			in_set_reg <= 1'b0;
		end else if (menu_p) begin
			in_menu_reg <= 1'b1;
			in_set_reg <= 1'b0;
		end else if (arrow_p) begin
			in_set_reg <= 1'b1;
			in_menu_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	wire alarm_act = (st_reg == ST_ALARM);
	wire alarm_on = fault_held(st_reg);
	wire prev_drive = prev_s & (st_reg != ST_ACKED);
	reg [2:0] screen_next;

	always @* begin
		if (inh_s) begin
			if (test_on_reg) begin
				screen_next = `IARC_SCR_TEST;
			end else if (in_menu_reg) begin
				screen_next = `IARC_SCR_MENU;
			end else if (in_set_reg) begin
				screen_next = `IARC_SCR_SETTINGS;
			end else begin
				screen_next = `IARC_SCR_INHIB;
			end
		end else if (test_on_reg) begin
			screen_next = `IARC_SCR_TEST;
		end else if (alarm_on) begin
			screen_next = `IARC_SCR_ALARM;
		end else if (prev_s) begin
			screen_next = `IARC_SCR_PREV;
		end else begin
			screen_next = `IARC_SCR_MEAS;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_relay <= 1'b0;
			alarm_relay <= 1'b0;
			prev_led <= 1'b0;
			alarm_led <= 1'b0;
			relay_connect <= 1'b1;
			screen <= `IARC_SCR_MEAS;
			test_active <= 1'b0;
		end else begin
			prev_relay <= prev_drive ^ test_rly_on_reg;
			alarm_relay <= ((alarm_act | pulse_on_reg) ^ test_rly_on_reg) | (inh_s & inh_fb);
			prev_led <= prev_s;
			alarm_led <= alarm_on;
			relay_connect <= ~(inh_s & ~inh_ext);
			screen <= screen_next;
			test_active <= test_on_reg;
		end
	end

	// ----------------------------------------
	// Interrupt events
	// ----------------------------------------
	wire [3:0] ev = {test_done, fault_clear, enter_alarm, rise[0]};
	wire clr_wr = wr_pend_reg & (addr_reg == `IARC_IRQ_CLR_OFS);
	assign irq = |(irq_stat_reg & irq_en_reg);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_reg <= 4'h0;
		end else begin
			irq_stat_reg <= ev | (irq_stat_reg & ~(clr_wr ? hwdata[3:0] : 4'h0));
		end
	end

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	wire take = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			rdata_reg <= 32'h0000_0000;
			ctrl_reg <= CTRL_RST[4:0];
			delay_reg <= 24'h00_0000;
			irq_en_reg <= 4'h0;
		end else begin
			wr_pend_reg <= take & hwrite;
			addr_reg <= haddr;
			if (wr_pend_reg) begin
				case (addr_reg)
					`IARC_CTRL_OFS: ctrl_reg <= hwdata[4:0];
					`IARC_DELAY_OFS: delay_reg <= hwdata[23:0];
					`IARC_IRQ_EN_OFS: irq_en_reg <= hwdata[3:0];
					default: ctrl_reg <= ctrl_reg;
				endcase
			end
			if (take && !hwrite) begin
				case (haddr)
					`IARC_CTRL_OFS: rdata_reg <= {27'h000_0000, ctrl_reg};
					`IARC_STATUS_OFS: rdata_reg <= {20'h0_0000, screen, test_active, st_reg, inh_s,
						alarm_s, prev_s, pulse_on_reg, alarm_relay, prev_relay};
					`IARC_DELAY_OFS: rdata_reg <= {8'h00, delay_reg};
					`IARC_IRQ_STAT_OFS: rdata_reg <= {28'h000_0000, irq_stat_reg};
					`IARC_IRQ_EN_OFS: rdata_reg <= {28'h000_0000, irq_en_reg};
					default: rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // iarc_top

/* File: testbench/iarc_loads.sv */
// Purpose: Horn and lamp loads hung on the two alarm relays.
// Assumes: A relay output is high while the relay is energised.
// Notes: The horn only sounds while the relay reaches the external network.
module iarc_loads (
	input wire alarm_relay,
	input wire prev_relay,
	input wire relay_connect,
	output wire horn_on,
	output wire lamp_on
);
	timeunit 1ns;
	timeprecision 1ps;
	assign horn_on = alarm_relay & relay_connect;
	assign lamp_on = prev_relay;
endmodule // iarc_loads

/* File: testbench/iarc_assertions.sv */
// Purpose: Port level checks of the alarm relay control block.
// Assumes: Pin levels pass two sync flops before they act.
// Notes: Run lengths of pin levels and pulses are counted in helper logic.
module iarc_assertions #(
	parameter PULSE_MS = 3000,
	parameter MS_DIV = 25000
) (
	input wire hclk,
	input wire hresetn,
	input wire prev_below,
	input wire alarm_below,
	input wire inhibit_in,
	input wire ack_btn,
	input wire menu_btn,
	input wire prev_relay,
	input wire alarm_relay,
	input wire prev_led,
	input wire alarm_led,
	input wire relay_connect,
	input wire [2:0] screen,
	input wire test_active
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIM = PULSE_MS * MS_DIV + MS_DIV + 4;
	wire [6:0] src = {test_active, alarm_relay & ~alarm_led & ~test_active & ~inhibit_in, ~inhibit_in, inhibit_in,
		prev_below, ~alarm_below, alarm_below};
	logic [31:0] run [7];
	always_ff @(posedge hclk or negedge hresetn) begin
		for (int i = 0; i < 7; i++) begin
			if (!hresetn)
				run[i] <= 32'h0000_0000;
			else
				run[i] <= src[i] ? run[i] + 32'h0000_0001 : 32'h0000_0000;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_inhibit_screen: assert property (run[3] >= 8 |-> screen inside {3'h3, 3'h4, 3'h5, 3'h6})
		else $error("screen left inhibit view while inhibited");
	chk_menu_key: assert property ($rose(menu_btn) && screen == 3'h3 |-> ##[1:6] screen == 3'h4)
		else $error("menu key did not open menu");
	chk_connect_cause: assert property (!relay_connect |-> run[4] < 6)
		else $error("relay disconnected without inhibit");
	chk_prev_led: assert property (run[2] >= 8 && !inhibit_in && !test_active |-> prev_led)
		else $error("preventive led off while below threshold");
	chk_alarm_cause: assert property ($rose(alarm_led) |-> run[0] >= 3)
		else $error("alarm led rose without a standing fault");
	chk_led_clear: assert property (run[1] >= 8 |-> !alarm_led)
		else $error("alarm led on after fault cleared");
	chk_pulse_bound: assert property (run[5] <= LIM)
		else $error("cleared pulse too long");
	chk_test_bound: assert property (run[6] <= LIM)
		else $error("self-test too long");
	chk_ack_outside: assert property ($rose(ack_btn) && screen == 3'h1 |-> ##1 $stable(prev_relay) [*5])
		else $error("ack outside alarm moved a relay");
	cov_alarm: cover property ($rose(alarm_led));
	cov_ack: cover property ($fell(alarm_relay) && alarm_led);
	cov_test: cover property ($rose(test_active));
endmodule // iarc_assertions

bind iarc_top iarc_assertions #(.PULSE_MS(PULSE_MS), .MS_DIV(MS_DIV)) u_iarc_assertions (.hclk(hclk),
	.hresetn(hresetn), .prev_below(prev_below), .alarm_below(alarm_below), .inhibit_in(inhibit_in),
	.ack_btn(ack_btn), .menu_btn(menu_btn), .prev_relay(prev_relay), .alarm_relay(alarm_relay),
	.prev_led(prev_led), .alarm_led(alarm_led), .relay_connect(relay_connect), .screen(screen),
	.test_active(test_active));

/* File: testbench/insulation_alarm_relay_control_bench.sv */
// Purpose: Directed tests of the alarm relay control block.
// Assumes: Pulse and test last 3 ms of 4 cycles each.
// Notes: Pins are driven as levels, buttons as short presses.
`include "iarc_regs.vh"
module insulation_alarm_relay_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, horn_on, lamp_on;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize, screen, pin;
	logic [3:0] btn;
	logic [31:0] hwdata, hrdata, rd;
	logic prev_relay, alarm_relay, prev_led, alarm_led, relay_connect, test_active;
	int n_fail, n_compared;
	assign hready = hreadyout;
	iarc_top #(.PULSE_MS(3), .MS_DIV(4)) u_iarc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .prev_below(pin[0]), .alarm_below(pin[1]), .inhibit_in(pin[2]),
		.ack_btn(btn[0]), .test_btn(btn[1]), .menu_btn(btn[2]), .arrow_btn(btn[3]), .prev_relay(prev_relay),
		.alarm_relay(alarm_relay), .prev_led(prev_led), .alarm_led(alarm_led), .relay_connect(relay_connect),
		.screen(screen), .test_active(test_active), .irq(irq));
	iarc_loads u_iarc_loads (.alarm_relay(alarm_relay), .prev_relay(prev_relay), .relay_connect(relay_connect),
		.horn_on(horn_on), .lamp_on(lamp_on));
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic setp(input int i, input logic v, input int n);
		@(posedge hclk);
		pin[i] <= v;
		cyc(n);
	endtask
	task automatic press(input int i);
		@(posedge hclk);
		btn[i] <= 1'b1;
		cyc(2);
		btn[i] <= 1'b0;
		cyc(4);
	endtask
	task automatic report_and_stop();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	initial begin
		cyc(5000);
		n_fail++;
		report_and_stop();
	end
	initial begin
		hresetn = 1'b0; hsel = 1'b0; htrans = 2'h0; haddr = 8'h00; hwrite = 1'b0; hsize = 3'h0;
		hwdata = 32'h0000_0000; pin = 3'h0; btn = 4'h0; n_fail = 0; n_compared = 0;
		cyc(4);
		hresetn <= 1'b1;
		bus(0, `IARC_CTRL_OFS, 0); chk("ctrl", 32'h0000_0005, rd);
		bus(0, 8'h40, 0); chk("unmapped", 0, rd);
		chk("hresp", 0, hresp);
		chk("hreadyout", 1, hreadyout);
		bus(1, `IARC_IRQ_EN_OFS, 32'h0000_000F);
		$display("reset test done");
		setp(0, 1, 10); chk("prev_relay", 1, lamp_on);
		chk("prev_led", 1, prev_led);
		chk("irq", 1, irq);
		bus(1, `IARC_IRQ_EN_OFS, 0); chk("irq masked", 0, irq);
		bus(1, `IARC_IRQ_EN_OFS, 32'h0000_000F);
		press(0); chk("prev_relay ack", 1, prev_relay);
		bus(1, `IARC_IRQ_CLR_OFS, 32'h0000_000F); chk("irq cleared", 0, irq);
		$display("preventive test done");
		bus(1, `IARC_DELAY_OFS, 32'h0000_0005);
		setp(1, 1, 10); setp(1, 0, 10); setp(1, 1, 10);
		chk("alarm early", 0, alarm_relay);
		cyc(30); chk("alarm_relay", 1, horn_on);
		chk("alarm_led", 1, alarm_led);
		chk("screen", `IARC_SCR_ALARM, screen);
		press(0); chk("acked relays", 0, {alarm_relay, prev_relay});
		bus(1, `IARC_CTRL_OFS, 32'h0000_0007);
		setp(0, 0, 0); setp(1, 0, 6); chk("pulse", 1, alarm_relay);
		cyc(20); chk("pulse end", 0, alarm_relay);
		chk("led clear", 0, alarm_led);
		chk("screen clear", `IARC_SCR_MEAS, screen);
		bus(0, `IARC_IRQ_STAT_OFS, 0); chk("irq stat", 32'h0000_0006, rd);
		$display("alarm ack test done");
		bus(1, `IARC_CTRL_OFS, 32'h0000_0006);
		setp(0, 1, 10); setp(1, 1, 40); press(0);
		chk("held relays", 3, {alarm_relay, prev_relay});
		setp(0, 0, 0); setp(1, 0, 6); chk("no pulse", 0, alarm_relay);
		$display("ack off test done");
		bus(1, `IARC_CTRL_OFS, 32'h0000_0005);
		press(1); chk("test relays", 7, {test_active, alarm_relay, prev_relay});
		cyc(20); chk("test end", 0, {test_active, alarm_relay, prev_relay});
		setp(2, 1, 10); chk("inh screen", `IARC_SCR_INHIB, screen);
		chk("connect int", 0, relay_connect);
		chk("no feedback", 0, alarm_relay);
		press(3); chk("settings", `IARC_SCR_SETTINGS, screen);
		press(1); chk("inh test", 1, test_active);
		cyc(20); setp(2, 0, 6); chk("auto test", 1, test_active);
		chk("auto no toggle", 0, {alarm_relay, prev_relay});
		cyc(20); chk("back meas", `IARC_SCR_MEAS, screen);
		$display("internal inhibit test done");
		bus(1, `IARC_CTRL_OFS, 32'h0000_0019);
		setp(2, 1, 10); chk("connect ext", 1, relay_connect);
		chk("feedback", 1, horn_on);
		press(2); chk("menu", `IARC_SCR_MENU, screen);
		setp(2, 0, 6); chk("ext no test", 0, test_active);
		chk("ext meas", `IARC_SCR_MEAS, screen);
		$display("external inhibit test done");
		report_and_stop();
	end
endmodule // insulation_alarm_relay_control_bench
